// ==== inc/emeter_pkg.sv ====
package emeter_pkg;
    // Register byte offsets on the APB side.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PCOUNT_OFS = 8'h08;
    localparam logic [7:0] POWER_OFS  = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CTRL_PULSE_EN_BIT = 0;

    // Current gain as a left shift: x1, x2, x8, x16.
    localparam logic [2:0] GAIN_SH_1  = 3'h0;
    localparam logic [2:0] GAIN_SH_2  = 3'h1;
    localparam logic [2:0] GAIN_SH_8  = 3'h3;
    localparam logic [2:0] GAIN_SH_16 = 3'h4;

    // Filter shifts; the power filter puts its corner near 8.9 Hz at the sample rate.
    localparam int HPF_SHIFT = 10;
    localparam int LPF_SHIFT = 9;
    localparam int AVG_SHIFT = 12;

    // Fault thresholds: 12.5 % is one eighth, 114 % is 57/50.
    localparam int FAULT_DIV_SHIFT = 3;
    localparam logic [7:0] SWAP_NUM = 8'h39;
    localparam logic [7:0] SWAP_DEN = 8'h32;
    localparam logic [15:0] LIGHT_LOAD_LEVEL = 16'h00a4;

    // Times and their cycle counts at the bus clock.
    localparam int CLK_HZ           = 40_000_000;
    localparam int FAULT_DELAY_MS   = 1000;
    localparam int SWAP_DELAY_MS    = 1200;
    localparam int SUPPLY_FILTER_US = 100;
    localparam int F_PULSE_MS       = 100;
    localparam int CF_PULSE_US      = 2;
    localparam int FAULT_DELAY_CYC  = CLK_HZ / 1000 * FAULT_DELAY_MS;
    localparam int SWAP_DELAY_CYC   = CLK_HZ / 1000 * SWAP_DELAY_MS;
    localparam int SUPPLY_FILT_CYC  = CLK_HZ / 1_000_000 * SUPPLY_FILTER_US;
    localparam int F_PULSE_CYC      = CLK_HZ / 1000 * F_PULSE_MS;
    localparam int CF_PULSE_CYC     = CLK_HZ / 1_000_000 * CF_PULSE_US;

    // Energy thresholds; the calibration threshold divides the low-rate one by 2**7 = 128.
    localparam int ACC_W = 48;
    localparam logic [47:0] F_THRESH_BASE = 48'h4000_0000_0000;
    localparam int CF_RATIO_SHIFT = 7;
endpackage

// ==== inc/fault_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fault_if;
    logic        sample_valid;
    logic [15:0] phase_mag;
    logic [15:0] neutral_mag;
    logic        fault;
    logic        use_neutral;
    modport source (output sample_valid, output phase_mag, output neutral_mag,
                    input fault, input use_neutral);
    modport detector (input sample_valid, input phase_mag, input neutral_mag,
                      output fault, output use_neutral);
endinterface
`default_nettype wire

// ==== verilog/supply_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module supply_monitor (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rail_above_high,
    input  wire logic rail_above_low,
    output logic      supply_ok
);
    logic [15:0] filt_q;
    logic        change;

    // Leave reset above the upper level, re-enter only below the lower one.
    always_comb change = supply_ok ? !rail_above_low : rail_above_high;

    // A change must persist for the whole filter window; noise restarts it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q    <= 16'h0000;
            supply_ok <= 1'b0;
        end else if (!change) begin
            filt_q <= 16'h0000;
        end else if (filt_q == 16'(emeter_pkg::SUPPLY_FILT_CYC - 1)) begin
            filt_q    <= 16'h0000;
            supply_ok <= !supply_ok;
        end else begin
            filt_q <= filt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/fault_detector.sv ====
`timescale 1ns/1ps
`default_nettype none
module fault_detector #(
    parameter int FAULT_DELAY = emeter_pkg::FAULT_DELAY_CYC,
    parameter int SWAP_DELAY  = emeter_pkg::SWAP_DELAY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    fault_if.detector fi
);
    localparam int AW = 16 + emeter_pkg::AVG_SHIFT;
    logic [AW-1:0] pavg_q, navg_q;
    logic [15:0]   pa, na, act, inact, diff;
    logic          light, differ, swap_want;
    logic [31:0]   fcnt_q, scnt_q;

    // Rectified averages of both inputs, so mains ripple does not trip logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pavg_q <= '0;
            navg_q <= '0;
        end else if (!run) begin
            pavg_q <= '0;
            navg_q <= '0;
        end else if (fi.sample_valid) begin
            // The step is signed so the average can fall as well as rise.
            pavg_q <= pavg_q + AW'(($signed({1'b0, fi.phase_mag, 12'h000})
                                    - $signed({1'b0, pavg_q})) >>> emeter_pkg::AVG_SHIFT);
            navg_q <= navg_q + AW'(($signed({1'b0, fi.neutral_mag, 12'h000})
                                    - $signed({1'b0, navg_q})) >>> emeter_pkg::AVG_SHIFT);
        end
    end

    // Fault and swap thresholds measured relative to the billed input; the light-load level is absolute.
    always_comb begin
        pa        = pavg_q[AW-1 -: 16];
        na        = navg_q[AW-1 -: 16];
        act       = fi.use_neutral ? na : pa;
        inact     = fi.use_neutral ? pa : na;
        diff      = (act > inact) ? act - inact : inact - act;
        light     = (pa < emeter_pkg::LIGHT_LOAD_LEVEL) && (na < emeter_pkg::LIGHT_LOAD_LEVEL);
        differ    = !light && (diff > (act >> emeter_pkg::FAULT_DIV_SHIFT));
        swap_want = !light && (24'(inact) * 24'(emeter_pkg::SWAP_DEN)
                               > 24'(act) * 24'(emeter_pkg::SWAP_NUM));
    end

    // Fault needs a sustained difference but drops at once when it vanishes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_q   <= 32'h0;
            fi.fault <= 1'b0;
        end else if (!run || !differ) begin
            fcnt_q   <= 32'h0;
            fi.fault <= 1'b0;
        end else if (fcnt_q == 32'(FAULT_DELAY - 1)) begin
            fi.fault <= 1'b1;
        end else begin
            fcnt_q <= fcnt_q + 32'h1;
        end
    end

    // Swap to the larger input after a sustained 114 % excess, either way.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scnt_q         <= 32'h0;
            fi.use_neutral <= 1'b0;
        end else if (!run) begin
            scnt_q         <= 32'h0;
            fi.use_neutral <= 1'b0;
        end else if (!swap_want || !differ) begin
            scnt_q <= 32'h0;
        end else if (scnt_q == 32'(SWAP_DELAY - 1)) begin
            scnt_q         <= 32'h0;
            fi.use_neutral <= !fi.use_neutral;
        end else begin
            scnt_q <= scnt_q + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/energy_meter_fault_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module energy_meter_fault_select #(
    parameter int FAULT_DELAY = emeter_pkg::FAULT_DELAY_CYC,
    parameter int SWAP_DELAY  = emeter_pkg::SWAP_DELAY_CYC,
    parameter int F_PULSE     = emeter_pkg::F_PULSE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        adc_sample_valid,
    input  wire logic [15:0] phase_current_input,
    input  wire logic [15:0] neutral_current_input,
    input  wire logic [15:0] voltage_positive_input,
    input  wire logic        gain_select_lsb,
    input  wire logic        gain_select_msb,
    input  wire logic        highpass_enable_pin,
    input  wire logic        rate_select_lsb,
    input  wire logic        rate_select_msb,
    input  wire logic        analog_supply_rail_above_high,
    input  wire logic        analog_supply_rail_above_low,
    output logic             fault_output,
    output logic             active_input_neutral,
    output logic             energy_pulse_out_a,
    output logic             energy_pulse_out_b,
    output logic             calibration_pulse_output
);
    localparam int GW = 20;
    localparam int PW = 36;
    localparam int DW = GW + emeter_pkg::HPF_SHIFT;
    localparam int LW = PW + emeter_pkg::LPF_SHIFT;
    localparam int AW = emeter_pkg::ACC_W;

    fault_if fi ();

    logic                 run;
    logic [31:0]          ctrl_q;
    logic [31:0]          pcount_q;
    logic                 pulse_en;
    logic                 hp_en;
    logic [1:0]           gsel, rsel;
    logic signed [GW-1:0] i_gain, i_hp, i_use;
    logic signed [DW-1:0] dc_q;
    logic signed [15:0]   v_q, v_dly_q, v_use;
    logic signed [PW-1:0] prod_q;
    logic signed [LW-1:0] lpf_q;
    logic signed [PW-1:0] power;
    logic signed [AW-1:0] facc_q, cfacc_q, fthr, cfthr;
    logic                 f_hit, cf_hit;
    logic [3:0]           f_pend_q, cf_pend_q;
    logic [31:0]          f_tmr_q;
    logic [15:0]          cf_tmr_q;
    logic                 f_side_q;
    logic                 f_start, cf_start;
    logic                 setup, wr_acc;

    // Map the two gain pins onto a left shift.
    function automatic logic [2:0] gain_shift(input logic [1:0] sel);
        case (sel)
            2'h0:    gain_shift = emeter_pkg::GAIN_SH_1;
            2'h1:    gain_shift = emeter_pkg::GAIN_SH_2;
            2'h2:    gain_shift = emeter_pkg::GAIN_SH_8;
            2'h3:    gain_shift = emeter_pkg::GAIN_SH_16;
            default: gain_shift = emeter_pkg::GAIN_SH_1;
        endcase
    endfunction

    // Magnitude of a sample, saturating the most negative code.
    function automatic logic [15:0] mag(input logic [15:0] x);
        if (x == 16'h8000) begin
            mag = 16'h7fff;
        end else begin
            mag = x[15] ? 16'(-x) : x;
        end
    endfunction

    supply_monitor u_supply (
        .pclk            (pclk),
        .presetn         (presetn),
        .rail_above_high (analog_supply_rail_above_high),
        .rail_above_low  (analog_supply_rail_above_low),
        .supply_ok       (run)
    );

    fault_detector #(
        .FAULT_DELAY (FAULT_DELAY),
        .SWAP_DELAY  (SWAP_DELAY)
    ) u_fault (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .fi      (fi.detector)
    );

    // The detector sees both raw currents, independent of the billing choice.
    assign fi.sample_valid = adc_sample_valid & run;
    assign fi.phase_mag    = mag(phase_current_input);
    assign fi.neutral_mag  = mag(neutral_current_input);

    // Static configuration pins and the bus enable.
    always_comb begin
        gsel     = {gain_select_msb, gain_select_lsb};
        rsel     = {rate_select_msb, rate_select_lsb};
        hp_en    = highpass_enable_pin;
        pulse_en = ctrl_q[emeter_pkg::CTRL_PULSE_EN_BIT];
    end

    // Billed current with gain applied, then optional dc removal.
    always_comb begin
        i_gain = GW'(signed'(fi.use_neutral ? neutral_current_input
                                            : phase_current_input)) <<< gain_shift(gsel);
        i_hp   = i_gain - dc_q[DW-1 -: GW];
        i_use  = hp_en ? i_hp : i_gain;
        v_use  = hp_en ? v_dly_q : v_q;
    end

    // The dc tracker follows slowly; its lag is why the voltage path is
    // delayed to match while the filter is in use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dc_q    <= '0;
            v_q     <= '0;
            v_dly_q <= '0;
        end else if (!run) begin
            dc_q    <= '0;
            v_q     <= '0;
            v_dly_q <= '0;
        end else if (adc_sample_valid) begin
            dc_q    <= dc_q + ((DW'(i_gain) <<< emeter_pkg::HPF_SHIFT) - dc_q
                               >>> emeter_pkg::HPF_SHIFT);
            v_q     <= signed'(voltage_positive_input);
            v_dly_q <= v_q;
        end
    end

    // Instantaneous power and its first-order smoothing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prod_q <= '0;
            lpf_q  <= '0;
        end else if (!run) begin
            prod_q <= '0;
            lpf_q  <= '0;
        end else if (adc_sample_valid) begin
            prod_q <= PW'(i_use * v_use);
            lpf_q  <= lpf_q + ((LW'(prod_q) <<< emeter_pkg::LPF_SHIFT) - lpf_q
                               >>> emeter_pkg::LPF_SHIFT);
        end
    end

    assign power = lpf_q[LW-1 -: PW];

    // Base rates are binary fractions: each rate step halves the threshold.
    always_comb begin
        fthr   = signed'(emeter_pkg::F_THRESH_BASE >> rsel);
        cfthr  = fthr >>> emeter_pkg::CF_RATIO_SHIFT;
        f_hit  = adc_sample_valid && (facc_q >= fthr);
        cf_hit = adc_sample_valid && (cfacc_q >= cfthr);
    end

    // Long accumulation for the low-rate outputs; ripple averages out here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            facc_q <= '0;
        end else if (!run) begin
            facc_q <= '0;
        end else if (adc_sample_valid) begin
            facc_q <= facc_q + AW'(power) - (f_hit ? fthr : '0);
        end
    end

    // Short accumulation for calibration; ripple is left for the counter to average.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfacc_q <= '0;
        end else if (!run) begin
            cfacc_q <= '0;
        end else if (adc_sample_valid) begin
            cfacc_q <= cfacc_q + AW'(power) - (cf_hit ? cfthr : '0);
        end
    end

    assign f_start  = (f_pend_q != 4'h0) && (f_tmr_q == 32'h0) && pulse_en;
    assign cf_start = (cf_pend_q != 4'h0) && (cf_tmr_q == 16'h0) && pulse_en;

    // Pending counts keep crossings that arrive while a pulse is in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_pend_q  <= 4'h0;
            cf_pend_q <= 4'h0;
        end else if (!run) begin
            f_pend_q  <= 4'h0;
            cf_pend_q <= 4'h0;
        end else begin
            if (f_hit && !f_start && f_pend_q != 4'hf) begin
                f_pend_q <= f_pend_q + 4'h1;
            end else if (!f_hit && f_start) begin
                f_pend_q <= f_pend_q - 4'h1;
            end
            if (cf_hit && !cf_start && cf_pend_q != 4'hf) begin
                cf_pend_q <= cf_pend_q + 4'h1;
            end else if (!cf_hit && cf_start) begin
                cf_pend_q <= cf_pend_q - 4'h1;
            end
        end
    end

    // Low-rate pulse: low for one width, then high for one width before the next.
    // Pulses alternate between the two outputs, suiting a two-phase stepper.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_tmr_q            <= 32'h0;
            f_side_q           <= 1'b0;
            energy_pulse_out_a <= 1'b1;
            energy_pulse_out_b <= 1'b1;
        end else if (!run) begin
            f_tmr_q            <= 32'h0;
            f_side_q           <= 1'b0;
            energy_pulse_out_a <= 1'b1;
            energy_pulse_out_b <= 1'b1;
        end else if (f_start) begin
            f_tmr_q            <= 32'(2 * F_PULSE - 1);
            f_side_q           <= !f_side_q;
            energy_pulse_out_a <= f_side_q;
            energy_pulse_out_b <= !f_side_q;
        end else if (f_tmr_q != 32'h0) begin
            f_tmr_q <= f_tmr_q - 32'h1;
            if (f_tmr_q == 32'(F_PULSE)) begin
                energy_pulse_out_a <= 1'b1;
                energy_pulse_out_b <= 1'b1;
            end
        end
    end

    // Calibration pulse uses the same shape with a short width.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cf_tmr_q                 <= 16'h0;
            calibration_pulse_output <= 1'b1;
        end else if (!run) begin
            cf_tmr_q                 <= 16'h0;
            calibration_pulse_output <= 1'b1;
        end else if (cf_start) begin
            cf_tmr_q                 <= 16'(2 * emeter_pkg::CF_PULSE_CYC - 1);
            calibration_pulse_output <= 1'b0;
        end else if (cf_tmr_q != 16'h0) begin
            cf_tmr_q <= cf_tmr_q - 16'h1;
            if (cf_tmr_q == 16'(emeter_pkg::CF_PULSE_CYC)) begin
                calibration_pulse_output <= 1'b1;
            end
        end
    end

    // Fault and billing choice are registered again for clean pin timing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_output         <= 1'b0;
            active_input_neutral <= 1'b0;
        end else begin
            fault_output         <= fi.fault;
            active_input_neutral <= fi.use_neutral;
        end
    end

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    // Control register; only the pulse enable bit is implemented.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= emeter_pkg::CTRL_RESET;
        end else if (wr_acc && paddr == emeter_pkg::CTRL_OFS) begin
            ctrl_q <= pwdata & emeter_pkg::CTRL_RESET;
        end
    end

    // Low-rate pulse counter; a write clears it, but a pulse in the same cycle is still counted, leaving 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcount_q <= 32'h0;
        end else if (wr_acc && paddr == emeter_pkg::PCOUNT_OFS) begin
            pcount_q <= f_start ? 32'h1 : 32'h0;
        end else if (f_start) begin
            pcount_q <= pcount_q + 32'h1;
        end
    end

    // Read data is captured in the setup phase so it is stable in the access phase.
    // Zero wait states: pready stays high once out of reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= 1'b0;
                case (paddr)
                    emeter_pkg::CTRL_OFS:   prdata <= ctrl_q;
                    emeter_pkg::STATUS_OFS: prdata <= {24'h0, rsel, gsel, hp_en, run,
                                                       fi.use_neutral, fi.fault};
                    emeter_pkg::PCOUNT_OFS: prdata <= pcount_q;
                    emeter_pkg::POWER_OFS:  prdata <= power[PW-1 -: 32];
                    default: begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/energy_meter_fault_select_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module emeter_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        gain_select_lsb,
    input wire logic        gain_select_msb,
    input wire logic        highpass_enable_pin,
    input wire logic        rate_select_lsb,
    input wire logic        rate_select_msb,
    input wire logic        analog_supply_rail_above_low,
    input wire logic        fault_output,
    input wire logic        active_input_neutral,
    input wire logic        energy_pulse_out_a,
    input wire logic        energy_pulse_out_b,
    input wire logic        calibration_pulse_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Status data is latched at the setup edge, so it shows the pins of that edge.
    sequence status_setup;
        psel && !penable && !pwrite && paddr == 8'h04;
    endsequence
    a_gain_status: assert property (status_setup |=> prdata[5] == $past(gain_select_msb)
        && prdata[4] == $past(gain_select_lsb)) else $error("gain status wrong");
    a_hpf_status: assert property (status_setup |=> prdata[3] == $past(highpass_enable_pin))
        else $error("filter status wrong");
    a_rate_status: assert property (status_setup |=> prdata[7] == $past(rate_select_msb)
        && prdata[6] == $past(rate_select_lsb)) else $error("rate status wrong");
    a_reset_phase: assert property ($rose(presetn) |-> !active_input_neutral
        && !fault_output) else $error("not phase billed after reset");
    a_swap_faulted: assert property ($rose(active_input_neutral) |-> fault_output)
        else $error("swap without fault");
    // A supply loss may cut a pulse short, but only after the lower trip has been
    // low for the whole filter window, so a pulse that starts with it high is not cut short within the filter window.
    a_pulse_width: assert property ($fell(energy_pulse_out_a) && analog_supply_rail_above_low
        |-> !energy_pulse_out_a [*8]) else $error("low-rate pulse too short");
    a_pulses_apart: assert property (energy_pulse_out_a || energy_pulse_out_b)
        else $error("both low-rate outputs low");
    a_cal_width: assert property ($fell(calibration_pulse_output)
        && analog_supply_rail_above_low |-> !calibration_pulse_output [*8])
        else $error("calibration pulse too short");
endmodule
bind energy_meter_fault_select emeter_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .gain_select_lsb, .gain_select_msb, .highpass_enable_pin, .rate_select_lsb,
    .rate_select_msb, .analog_supply_rail_above_low, .fault_output, .active_input_neutral,
    .energy_pulse_out_a,
    .energy_pulse_out_b, .calibration_pulse_output);
`default_nettype wire

// ==== sim/pulse_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic energy_pulse_out_a,
    input wire logic energy_pulse_out_b,
    input wire logic calibration_pulse_output,
    output var int   low_count,
    output var int   cal_count
);
    logic a_q, b_q, cf_q;
    // Counting falling edges keeps the tally right whatever the pulse length.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {a_q, b_q, cf_q} <= 3'h7;
            low_count <= 0;
            cal_count <= 0;
        end else begin
            {a_q, b_q, cf_q} <= {energy_pulse_out_a, energy_pulse_out_b, calibration_pulse_output};
            low_count <= low_count + int'(a_q & !energy_pulse_out_a) + int'(b_q & !energy_pulse_out_b);
            cal_count <= cal_count + int'(cf_q & !calibration_pulse_output);
        end
    end
endmodule
`default_nettype wire

// ==== sim/energy_meter_fault_select_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module energy_meter_fault_select_bench;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, adc_sample_valid = 1'h0;
    logic [15:0] phase_current_input = 16'h0, neutral_current_input = 16'h0;
    logic [15:0] voltage_positive_input = 16'h0;
    logic        gain_select_lsb = 1'h0, gain_select_msb = 1'h0, highpass_enable_pin = 1'h0;
    logic        rate_select_lsb = 1'h0, rate_select_msb = 1'h0;
    logic        analog_supply_rail_above_high = 1'h1, analog_supply_rail_above_low = 1'h1;
    logic        fault_output, active_input_neutral, calibration_pulse_output;
    logic        energy_pulse_out_a, energy_pulse_out_b;
    int          failures = 0, total_checks = 0, n, cnt_ab, cnt_cf;
    // Short delays keep the run brief; the supply filter keeps its full length, so its waits run 4100 cycles.
    energy_meter_fault_select #(.FAULT_DELAY(50), .SWAP_DELAY(60), .F_PULSE(20)) uut (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .adc_sample_valid, .phase_current_input, .neutral_current_input, .voltage_positive_input,
        .gain_select_lsb, .gain_select_msb, .highpass_enable_pin, .rate_select_lsb,
        .rate_select_msb, .analog_supply_rail_above_high, .analog_supply_rail_above_low,
        .fault_output, .active_input_neutral, .energy_pulse_out_a, .energy_pulse_out_b,
        .calibration_pulse_output);
    pulse_counter far (.pclk, .presetn, .energy_pulse_out_a, .energy_pulse_out_b,
        .calibration_pulse_output, .low_count(cnt_ab), .cal_count(cnt_cf));
    // The clock runs at 40 MHz.
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // A hang is cut short well after the longest expected run.
    initial begin
        #(95000 * 25);
        failures++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        {presetn, adc_sample_valid} <= 2'h3;
        repeat (4100) @(posedge pclk);
        apb(1'h0, 8'h04, 32'h0);
        chk(32'(rd[2]), 32'h1);
        chk(32'(fault_output), 32'h0);
        // Only the pulse enable bit of the control register exists.
        apb(1'h1, 8'h00, 32'hffff_ffff);
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0000_0001);
        for (n = 0; n < 4; n++) begin
            {gain_select_msb, gain_select_lsb, rate_select_msb, rate_select_lsb} <= 4'(n * 4 + 3 - n);
            highpass_enable_pin <= n[0];
            apb(1'h0, 8'h04, 32'h0);
            chk(32'(rd[7:3]), 32'({2'(3 - n), n[1:0], n[0]}));
        end
        {highpass_enable_pin, rate_select_msb, rate_select_lsb} <= 3'h3;
        {phase_current_input, voltage_positive_input} <= {16'h07ff, 16'h7fff};
        apb(1'h1, 8'h08, 32'h0);
        repeat (20000) @(posedge pclk);
        chk(32'(fault_output), 32'h1);
        chk(32'(active_input_neutral), 32'h0);
        chk(32'(cnt_ab > 0), 32'h1);
        chk(32'(cnt_cf > cnt_ab), 32'h1);
        {phase_current_input, neutral_current_input} <= {16'h0000, 16'h07ff};
        for (n = 0; n < 30000 && active_input_neutral !== 1'h1; n++) @(posedge pclk);
        chk(32'({active_input_neutral, fault_output}), 32'h3);
        phase_current_input <= 16'h07ff;
        for (n = 0; n < 30000 && fault_output !== 1'h0; n++) @(posedge pclk);
        chk(32'({active_input_neutral, fault_output}), 32'h2);
        analog_supply_rail_above_low <= 1'h0;
        repeat (10) @(posedge pclk);
        analog_supply_rail_above_low <= 1'h1;
        apb(1'h0, 8'h04, 32'h0);
        chk(32'(rd[2]), 32'h1);
        {analog_supply_rail_above_high, analog_supply_rail_above_low} <= 2'h0;
        repeat (4100) @(posedge pclk);
        apb(1'h0, 8'h04, 32'h0);
        chk(32'(rd[2:0]), 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'(cnt_ab));
        apb(1'h0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
